// ### hdl/pwt_consts.svh
// constants for the prescaled watchdog timer
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH
// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define PWT_ADDR_CONTROL   8'h00
`define PWT_ADDR_AUTOLOAD  8'h04
`define PWT_ADDR_FEED1     8'h08
`define PWT_ADDR_FEED2     8'h0c
`define PWT_ADDR_COUNT     8'h10
// ------------------------------------------------------------
// feed keys
// ------------------------------------------------------------
`define PWT_KEY_FIRST      8'ha5
`define PWT_KEY_SECOND     8'h5a
// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define PWT_BIT_TAP_HI     7
`define PWT_BIT_TAP_LO     5
`define PWT_BIT_LV_RST_EN  4
`define PWT_BIT_OSC_RST_EN 3
`define PWT_BIT_RUN        2
`define PWT_BIT_TOF        1
`define PWT_BIT_MODE       0
`define PWT_RST_TAP        3'h7
`define PWT_RST_AUTOLOAD   8'h00
`define PWT_RST_CTRL       8'hff
// ------------------------------------------------------------
// prescaler
// ------------------------------------------------------------
`define PWT_DIV_FIRST      4'hb
`define PWT_STAGES         13
`define PWT_FIRST_TAP      6
`endif

// ### hdl/pwt_pkg.sv
// types for the prescaled watchdog timer
`default_nettype none
package pwt_pkg;
  typedef enum logic [2:0]
  {
    FEED_IDLE  = 3'b001,
    FEED_ARMED = 3'b010,
    FEED_FIRE  = 3'b100
  } pwt_feed_t;
endpackage : pwt_pkg
`default_nettype wire

// ### hdl/pwt_prescaler.sv
// divide-by-12 and 13-stage prescaler with selectable tap
`timescale 1ns/100ps
`default_nettype none
`include "pwt_consts.svh"
module pwt_prescaler
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic [2:0] tap,
  // tick out
  output logic            tick
);
  logic [3:0]               div_reg;
  logic [`PWT_STAGES-1:0]   stage_reg;
  logic                     div_en;
  logic [`PWT_STAGES-1:0]   stage_next;
  logic [`PWT_STAGES-1:0]   carry;

  // ----------------------------------------------------------
  // divide by 12
  // ----------------------------------------------------------
  assign div_en = (div_reg == `PWT_DIV_FIRST);
  always_ff @(posedge clk)
  begin
    if (rst || clear || div_en)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  // ----------------------------------------------------------
  // 13-stage ripple-style counter, carry per stage
  // ----------------------------------------------------------
  assign stage_next = stage_reg + {{(`PWT_STAGES-1){1'b0}}, 1'b1};
  genvar i;
  generate
    for (i = 0; i < `PWT_STAGES; i = i + 1)
    begin : g_carry
      assign carry[i] = div_en & (&stage_reg[i:0]);
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    if (rst || clear)
      stage_reg <= '0;
    else if (div_en)
      stage_reg <= stage_next;
  end

  // tap code n picks the carry out of stage 6+n
  assign tick = carry[`PWT_FIRST_TAP - 1 + {29'h0, tap}];
endmodule : pwt_prescaler
`default_nettype wire

// ### hdl/pwt_counter.sv
// 8-bit main down counter with autoload
`timescale 1ns/100ps
`default_nettype none
`include "pwt_consts.svh"
module pwt_counter #(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // control
  input  wire logic             load,
  input  wire logic             dec,
  input  wire logic [WIDTH-1:0] load_val,
  // state
  output logic [WIDTH-1:0]      count,
  output logic                  underflow
);
  logic [WIDTH-1:0] count_reg;
  assign count = count_reg;
  // underflow on a decrement while at zero
  assign underflow = dec && (count_reg == '0);
  always_ff @(posedge clk)
  begin
    if (rst)
      count_reg <= `PWT_RST_AUTOLOAD;
    else if (load || underflow)
      count_reg <= load_val;
    else if (dec)
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule : pwt_counter
`default_nettype wire

// ### hdl/pwt_top.sv
// prescaled watchdog timer with AHB-Lite register slave
// What this block does
// - correct first key but wrong second key forces an immediate underflow
// - counter not writable; a feed loads it from the autoload value
// - watchdog mode underflow resets system; timer mode only sets the flag
// - oscillator divided by 12 then 13 stages; one of stages 6..13 clocks counter
// - 8-bit counter decrements per tick; tick at zero underflows and reloads
// - autoload takes 0..ff; each autoload clears the prescaler
// - reset: watchdog mode, run on, autoload 00, flag clear, top tap, autoload
// - a valid feed works in timer mode as in watchdog mode
// - reset coinciding with underflow wins and leaves the flag cleared
// - watchdog underflow autoloads, sets flag, keeps settings, resets the system
// - timer underflow autoloads, sets flag, keeps settings, no reset
// - timeout flag stays set until software clears it
// - access pin low uses registers; high uses mask-programmed parameters
// - pin high with mask timer mode still takes autoload and tap from registers
// - pin high: mode reads mask value; mask watchdog mode ignores run
// - timeout = tosc * 12 * 64 * 2^tap * (autoload + 1)
// - control register takes writes only directly after the first key of a feed
// - mode and tap go to a shadow register copied on each feed
// - control: tap 7..5, low-voltage enable 4, osc-fail enable 3, run 2, flag 1, mode 0
// - no interrupt request is ever raised
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pwt_consts.svh"
module pwt_top #(
  parameter logic       MASK_MODE     = 1'b1,
  parameter logic       MASK_RUN      = 1'b1,
  parameter logic [2:0] MASK_TAP      = 3'h7,
  parameter logic [7:0] MASK_AUTOLOAD = 8'h00
)
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // pins
  input  wire logic        EXTERNAL_ACCESS_PIN,
  output logic             SYSTEM_RESET,
  output logic             LOW_VOLTAGE_RESET_ENABLE,
  output logic             OSC_FAIL_RESET_ENABLE
);
  // ----------------------------------------------------------
  // declarations
  // ----------------------------------------------------------
  logic                ext_access_meta_reg;
  logic                ext_access_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic                rd_pend_reg;
  logic [31:0]         hrdata_reg;
  logic [7:0]          user_ctrl_reg;
  logic [7:0]          autoload_reg;
  logic [2:0]          sh_tap_reg;
  logic                sh_mode_reg;
  logic                sh_run_reg;
  logic                tof_reg;
  logic                sysrst_reg;
  logic                low_voltage_reset_enable_reg;
  logic                osc_fail_reset_enable_reg;
  pwt_pkg::pwt_feed_t  feed_reg;
  pwt_pkg::pwt_feed_t  feed_next;
  logic                addr_ok;
  logic                wr_ctrl;
  logic                wr_auto;
  logic                wr_f1;
  logic                wr_f2;
  logic                feed_ok;
  logic                feed_bad;
  logic                eff_mode;
  logic                eff_run;
  logic [2:0]          eff_tap;
  logic [7:0]          eff_load;
  logic                tick;
  logic                dec;
  logic                underflow;
  logic                expire;
  logic                reload;
  logic [7:0]          count;
  logic [7:0]          ctrl_view;
  logic [7:0]          wbyte;
  logic                ctrl_unlock;

  // ----------------------------------------------------------
  // access pin synchroniser
  // ----------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    ext_access_meta_reg <= EXTERNAL_ACCESS_PIN;
    ext_access_reg      <= ext_access_meta_reg;
  end

  // ----------------------------------------------------------
  // ahb-lite address phase capture, zero wait states
  // ----------------------------------------------------------
  // only the low address byte is decoded
  assign addr_ok = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_ok && HWRITE;
      rd_pend_reg <= addr_ok && !HWRITE;
      if (addr_ok)
      begin
        wr_addr_reg <= HADDR[7:0];
      end
    end
  end

  // only the low byte of each word carries data
  assign wbyte   = HWDATA[7:0];
  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `PWT_ADDR_CONTROL);
  assign wr_auto = wr_pend_reg && (wr_addr_reg == `PWT_ADDR_AUTOLOAD);
  assign wr_f1   = wr_pend_reg && (wr_addr_reg == `PWT_ADDR_FEED1);
  assign wr_f2   = wr_pend_reg && (wr_addr_reg == `PWT_ADDR_FEED2);
  // a control write counts only right after the first key
  assign ctrl_unlock = wr_ctrl && (feed_reg == pwt_pkg::FEED_ARMED);

  // ----------------------------------------------------------
  // feed sequence: any bus read or write between the keys breaks it
  // ----------------------------------------------------------
  always_comb
  begin
    feed_next = pwt_pkg::FEED_IDLE;
    unique case (feed_reg)
      pwt_pkg::FEED_IDLE,
      pwt_pkg::FEED_FIRE:
      begin
        if (wr_f1 && wbyte == `PWT_KEY_FIRST)
          feed_next = pwt_pkg::FEED_ARMED;
      end
      pwt_pkg::FEED_ARMED:
      begin
        if (wr_f2 && wbyte == `PWT_KEY_SECOND)
          feed_next = pwt_pkg::FEED_FIRE;
        else if (wr_pend_reg || rd_pend_reg)
          feed_next = pwt_pkg::FEED_IDLE;
        else
          feed_next = pwt_pkg::FEED_ARMED;
      end
      default:
        feed_next = pwt_pkg::FEED_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      feed_reg <= pwt_pkg::FEED_IDLE;
    else
      feed_reg <= feed_next;
  end

  // a feed acts in either mode
  assign feed_ok  = (feed_reg == pwt_pkg::FEED_ARMED) && wr_f2 && wbyte == `PWT_KEY_SECOND;
  assign feed_bad = (feed_reg == pwt_pkg::FEED_ARMED) && wr_f2 && wbyte != `PWT_KEY_SECOND;

  // ----------------------------------------------------------
  // user registers
  // ----------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      autoload_reg <= `PWT_RST_AUTOLOAD;
    else if (wr_auto)
      autoload_reg <= wbyte;
  end

  // control writes land only when they directly follow the first key
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      user_ctrl_reg <= `PWT_RST_CTRL;
    else if (ctrl_unlock)
      user_ctrl_reg <= wbyte;
  end

  // ----------------------------------------------------------
  // shadow control, copied on feed
  // ----------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      sh_tap_reg  <= `PWT_RST_TAP;
      sh_mode_reg <= 1'b1;
      sh_run_reg  <= 1'b1;
      low_voltage_reset_enable_reg <= 1'b1;
      osc_fail_reset_enable_reg    <= 1'b1;
    end
    else if (feed_ok)
    begin
      sh_tap_reg  <= user_ctrl_reg[`PWT_BIT_TAP_HI:`PWT_BIT_TAP_LO];
      sh_mode_reg <= user_ctrl_reg[`PWT_BIT_MODE];
      sh_run_reg  <= user_ctrl_reg[`PWT_BIT_RUN];
      low_voltage_reset_enable_reg <= user_ctrl_reg[`PWT_BIT_LV_RST_EN];
      osc_fail_reset_enable_reg    <= user_ctrl_reg[`PWT_BIT_OSC_RST_EN];
    end
  end

  // ----------------------------------------------------------
  // parameter source selection
  // ----------------------------------------------------------
  always_comb
  begin
    eff_mode = sh_mode_reg;
    eff_run  = sh_run_reg;
    eff_tap  = sh_tap_reg;
    eff_load = autoload_reg;
    // mask mode replaces the register mode while the access pin is high; mask watchdog mode also replaces run, tap and autoload
    if (ext_access_reg)
    begin
      eff_mode = MASK_MODE;
      if (MASK_MODE)
      begin
        eff_run  = 1'b1;
        eff_tap  = MASK_TAP;
        eff_load = MASK_AUTOLOAD;
      end
      else
        eff_run = sh_run_reg;
    end
  end

  // ----------------------------------------------------------
  // prescaler and main counter
  // ----------------------------------------------------------
  // every autoload clears the prescaler
  assign reload   = feed_ok || expire;
  assign dec      = tick && eff_run;
  // a wrong second key expires at once
  assign expire   = underflow || feed_bad;

  pwt_prescaler u_pre
  (
    .clk   (CLK_SYS),
    .rst   (RESET),
    .clear (reload),
    .tap   (eff_tap),
    .tick  (tick)
  );

  // the counter itself is never written by software
  pwt_counter #(
    .WIDTH (8)
  ) u_cnt
  (
    .clk       (CLK_SYS),
    .rst       (RESET),
    .load      (reload),
    .dec       (dec),
    .load_val  (eff_load),
    .count     (count),
    .underflow (underflow)
  );

  // ----------------------------------------------------------
  // timeout flag and system reset
  // ----------------------------------------------------------
  // set wins over clear; reset wins over all
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      tof_reg <= 1'b0;
    else if (expire)
      tof_reg <= 1'b1;
    // software clears the flag with a zero written after the first key
    else if (ctrl_unlock && !wbyte[`PWT_BIT_TOF])
      tof_reg <= 1'b0;
  end

  // one-cycle reset request, watchdog mode only
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      sysrst_reg <= 1'b0;
    else
      sysrst_reg <= expire && eff_mode;
  end

  // ----------------------------------------------------------
  // read data
  // ----------------------------------------------------------
  assign ctrl_view = {eff_tap, low_voltage_reset_enable_reg, osc_fail_reset_enable_reg,
                      eff_run, tof_reg, eff_mode};
  // read data is taken in the address phase and stands in the data phase

  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
      hrdata_reg <= 32'h0000_0000;
    else if (addr_ok && !HWRITE)
    begin
      unique case (HADDR[7:0])
        `PWT_ADDR_CONTROL:  hrdata_reg <= {24'h0, ctrl_view};
        `PWT_ADDR_AUTOLOAD: hrdata_reg <= {24'h0, autoload_reg};
        `PWT_ADDR_COUNT:    hrdata_reg <= {24'h0, count};
        default:            hrdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // outputs; no interrupt output exists
  // ----------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      HREADYOUT                <= 1'b1;
      HRESP                    <= 1'b0;
      LOW_VOLTAGE_RESET_ENABLE <= 1'b1;
      OSC_FAIL_RESET_ENABLE    <= 1'b1;
    end
    else
    begin
      HREADYOUT                <= 1'b1;
      HRESP                    <= 1'b0;
      LOW_VOLTAGE_RESET_ENABLE <= low_voltage_reset_enable_reg;
      OSC_FAIL_RESET_ENABLE    <= osc_fail_reset_enable_reg;
    end
  end
  assign HRDATA       = hrdata_reg;
  assign SYSTEM_RESET = sysrst_reg;
endmodule : pwt_top
`default_nettype wire

// ### test/pwt_checker.sv
// port-level assertions for the prescaled watchdog timer
`timescale 1ns/100ps
`default_nettype none
`include "pwt_consts.svh"
module pwt_checker
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // bus
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  // pins
  input wire logic        SYSTEM_RESET,
  input wire logic        LOW_VOLTAGE_RESET_ENABLE,
  input wire logic        OSC_FAIL_RESET_ENABLE
);
  // ----------------------------------------
  // feed tracking
  // ----------------------------------------
  logic       ph_valid;
  logic       ph_wr;
  logic       key1_seen;
  logic [7:0] ph_addr;
  logic       good_feed;
  logic       rd_taken;
  assign rd_taken = HSEL && HREADY && HTRANS[1] && !HWRITE;
  assign good_feed = ph_valid && ph_wr && key1_seen && ph_addr == `PWT_ADDR_FEED2
    && HWDATA[7:0] == `PWT_KEY_SECOND;
  always_ff @(posedge CLK_SYS)
  begin
    if (RESET)
    begin
      ph_valid  <= 1'b0;
      ph_wr     <= 1'b0;
      ph_addr   <= 8'h00;
      key1_seen <= 1'b0;
    end
    else
    begin
      ph_valid <= HSEL && HREADY && HTRANS[1];
      ph_wr    <= HWRITE;
      ph_addr  <= HADDR[7:0];
      if (ph_valid)
        key1_seen <= ph_wr && ph_addr == `PWT_ADDR_FEED1 && HWDATA[7:0] == `PWT_KEY_FIRST;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_reset_outs: assert property ($fell(RESET) |->
    !SYSTEM_RESET && LOW_VOLTAGE_RESET_ENABLE && OSC_FAIL_RESET_ENABLE)
    else $error("outputs wrong after reset");
  a_feed_quiet: assert property (good_feed |-> ##1 (!SYSTEM_RESET)[*8])
    else $error("reset pulse right after a good feed");
  a_expiry_gap: assert property ($rose(SYSTEM_RESET) |=> (!SYSTEM_RESET)[*8])
    else $error("reset pulse too long or repeated");
  a_enable_hold: assert property (!$past(RESET) && (!$stable(LOW_VOLTAGE_RESET_ENABLE)
    || !$stable(OSC_FAIL_RESET_ENABLE)) |-> $past(good_feed) || $past(good_feed, 2))
    else $error("enable changed without a feed");
  a_upper_zero: assert property (HRDATA[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (rd_taken && HADDR[7:0] > 8'h10 |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  a_ready_okay: assert property (HREADYOUT && !HRESP)
    else $error("slave not ready or not okay");
  a_rdata_hold: assert property (!$past(RESET) && !$stable(HRDATA) |-> $past(rd_taken))
    else $error("read data changed without a read");
endmodule : pwt_checker
`default_nettype wire

// ### test/prescaled_watchdog_timer_test.sv
// self-checking testbench for the prescaled watchdog timer
`timescale 1ns/100ps
`default_nettype none
`include "pwt_consts.svh"
module prescaled_watchdog_timer_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        CLK_SYS, RESET, HSEL, HWRITE, HREADY, EXTERNAL_ACCESS_PIN;
  logic        HREADYOUT, HRESP, SYSTEM_RESET;
  logic        LOW_VOLTAGE_RESET_ENABLE, OSC_FAIL_RESET_ENABLE;
  logic [31:0] HADDR, HWDATA, HRDATA, rd_v;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  int          error_cnt, checked, pulses, n, p0;
  localparam logic [7:0] CTL = `PWT_ADDR_CONTROL;
  localparam logic [7:0] ALD = `PWT_ADDR_AUTOLOAD;
  localparam logic [7:0] CNT = `PWT_ADDR_COUNT;
  assign HREADY = HREADYOUT;
  pwt_top dut_u (.CLK_SYS, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .EXTERNAL_ACCESS_PIN, .SYSTEM_RESET,
    .LOW_VOLTAGE_RESET_ENABLE, .OSC_FAIL_RESET_ENABLE);
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (SYSTEM_RESET === 1'b1) pulses++;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task test_done();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task edge_rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge CLK_SYS);
      k++;
    end
    while (HREADYOUT !== 1'b1 && k < 64);
    if (k >= 64)
    begin
      error_cnt++;
      test_done();
    end
  endtask : edge_rdy
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    edge_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, d};
    edge_rdy();
    rd_v = HRDATA;
  endtask : bus
  task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd_v);
  endtask : rd_chk
  task feed(input logic [7:0] k2);
    bus(1'b1, `PWT_ADDR_FEED1, `PWT_KEY_FIRST);
    bus(1'b1, `PWT_ADDR_FEED2, k2);
  endtask : feed
  task set_ctl(input logic [7:0] v);
    bus(1'b1, `PWT_ADDR_FEED1, `PWT_KEY_FIRST);
    bus(1'b1, CTL, v);
  endtask : set_ctl
  task wait_pulse(input int lim);
    n = 0;
    while (SYSTEM_RESET !== 1'b1 && n < lim)
    begin
      @(negedge CLK_SYS);
      n++;
    end
    @(posedge CLK_SYS);
  endtask : wait_pulse
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    rd_chk("ctl reset", CTL, 8'hfd);
    rd_chk("autoload reset", ALD, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    chk("enables", 32'h3, {30'h0, LOW_VOLTAGE_RESET_ENABLE, OSC_FAIL_RESET_ENABLE});
  endtask : t_reset
  task t_locked();
    bus(1'b1, CTL, 8'h00);
    rd_chk("ctl locked", CTL, 8'hfd);
    bus(1'b1, CNT, 8'hff);
    rd_chk("count ro", CNT, 8'h00);
  endtask : t_locked
  task t_timer();
    bus(1'b1, ALD, 8'h02);
    set_ctl(8'h0c);
    chk("shadow wait", 32'h1, {31'h0, LOW_VOLTAGE_RESET_ENABLE});
    feed(`PWT_KEY_SECOND);
    p0 = pulses;
    rd_chk("count fed", CNT, 8'h02);
    chk("shadow copy", 32'h0, {31'h0, LOW_VOLTAGE_RESET_ENABLE});
    repeat (2150) @(posedge CLK_SYS);
    rd_chk("flag early", CTL, 8'h0c);
    repeat (200) @(posedge CLK_SYS);
    rd_chk("flag timer", CTL, 8'h0e);
    rd_chk("count reload", CNT, 8'h02);
    chk("no reset", p0, pulses);
    set_ctl(8'h0c);
    rd_chk("flag clear", CTL, 8'h0c);
  endtask : t_timer
  task t_watchdog();
    bus(1'b1, ALD, 8'h00);
    set_ctl(8'h1d);
    feed(`PWT_KEY_SECOND);
    wait_pulse(900);
    chk("expiry time", 32'h1, {31'h0, n >= 766 && n <= 772});
    rd_chk("flag watchdog", CTL, 8'h1f);
  endtask : t_watchdog
  task t_bad_key();
    set_ctl(8'h1d);
    feed(8'h33);
    wait_pulse(8);
    chk("bad key", 32'h1, {31'h0, n < 8});
    rd_chk("flag bad key", CTL, 8'h1f);
  endtask : t_bad_key
  task t_coincide();
    feed(`PWT_KEY_SECOND);
    p0 = pulses;
    repeat (767) @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (16) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    chk("coincide pulse", p0, pulses);
    rd_chk("flag coincide", CTL, 8'hfd);
    rd_chk("autoload again", ALD, 8'h00);
  endtask : t_coincide
  task t_pin();
    EXTERNAL_ACCESS_PIN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    set_ctl(8'he0);
    feed(`PWT_KEY_SECOND);
    bus(1'b0, CTL, 8'h00);
    chk("mask mode", 32'he1, rd_v & 32'he1);
    chk("enables off", 32'h0, {30'h0, LOW_VOLTAGE_RESET_ENABLE, OSC_FAIL_RESET_ENABLE});
  endtask : t_pin
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    RESET = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    EXTERNAL_ACCESS_PIN = 1'b0;
    error_cnt = 0;
    checked = 0;
    pulses = 0;
    repeat (4) @(posedge CLK_SYS);
    RESET <= 1'b0;
    @(posedge CLK_SYS);
    t_reset();
    t_locked();
    t_timer();
    t_watchdog();
    t_bad_key();
    t_coincide();
    t_pin();
    test_done();
  end
endmodule : prescaled_watchdog_timer_test
bind pwt_top pwt_checker chk_u (.CLK_SYS, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .SYSTEM_RESET, .LOW_VOLTAGE_RESET_ENABLE,
  .OSC_FAIL_RESET_ENABLE);
`default_nettype wire
